// ---- psw_sysmask_ctl.sv ----
`timescale 1ns/100ps
`include "psw_sysmask_consts.svh"
module psw_sysmask_ctl (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire psw_sysmask_pkg::mask_op_e op_in,
  input wire logic op_privileged_in,
  input wire logic [31:0] op_data_in,
  input wire logic restore_in,
  input wire logic [63:0] restore_data_in,
  input wire logic interruption_in,
  input wire psw_sysmask_pkg::intr_state_s intr_state_in,
  input wire logic legacy_mode_in,
  input wire logic legacy_cfg_intr_flag_in,
  input wire logic legacy_flags_intr_bit_in,
  input wire logic ext_intr_pending_in,
  input wire logic nmi_pending_in,
  input wire logic spec_exc_in,
  input wire logic defer_by_ctl_in,
  input wire logic fp_access_in,
  input wire logic [6:0] fp_reg_in,
  input wire logic legacy_fp_instr_in,
  input wire logic isa_switch_branch_in,
  input wire logic instr_retire_in,
  output logic [63:0] processor_status_word_out,
  output psw_sysmask_pkg::intr_state_s saved_state_out,
  output psw_sysmask_pkg::mem_ctl_s mem_ctl_out,
  output logic ext_intr_take_out,
  output logic nmi_take_out,
  output logic spec_defer_out,
  output logic fp_disabled_fault_out
);
  logic [63:0] psw_q;
  logic [63:0] psw_d;
  logic first_legacy_q;
  logic first_legacy_d;
  logic ext_take_q;
  logic nmi_take_q;
  logic defer_q;
  logic fp_fault_q;
  psw_sysmask_pkg::mem_ctl_s mem_ctl_q;

  wire logic [63:0] mask_field = {40'h00_0000_0000, `SYSMASK_FIELD};
  wire logic [63:0] op_bits = {32'h0000_0000, op_data_in} & mask_field;
  wire logic op_ok = op_privileged_in && !interruption_in;
  wire logic do_set = op_ok && (op_in == psw_sysmask_pkg::OP_SET_MASK);
  wire logic do_clr = op_ok && (op_in == psw_sysmask_pkg::OP_CLR_MASK);
  wire logic do_move = op_ok && (op_in == psw_sysmask_pkg::OP_MOVE_LOW);
  wire logic capture_on = psw_q[`BIT_CAPTURE];
  wire logic save_load = interruption_in && capture_on;
  // Clear op is visible on the same cycle so the next instruction sees it
  wire logic intr_eff = psw_q[`BIT_INTR] && !(do_clr && op_bits[`BIT_INTR]);
  wire logic legacy_ok = !legacy_cfg_intr_flag_in || legacy_flags_intr_bit_in;
  wire logic ext_en = legacy_mode_in ? (intr_eff && legacy_ok) : intr_eff;
  wire logic key_on = psw_q[`BIT_KEYCHK];
  wire logic fp_lo_hit = fp_reg_in >= `FP_LO_FIRST && fp_reg_in <= `FP_LO_LAST;
  wire logic fp_hi_hit = fp_reg_in >= `FP_HI_FIRST;
  wire logic lo_fault = psw_q[`BIT_FPLO_DIS] && ((fp_access_in && fp_lo_hit) || legacy_fp_instr_in);
  wire logic hi_fault = psw_q[`BIT_FPHI_DIS] && ((fp_access_in && fp_hi_hit)
    || (legacy_mode_in && instr_retire_in && first_legacy_q));
  wire logic ext_take_d = ext_en && ext_intr_pending_in;
  // Native mode leaves non-maskable interrupts ungated
  wire logic nmi_take_d = legacy_mode_in ? (intr_eff && nmi_pending_in) : nmi_pending_in;
  wire logic defer_d = spec_exc_in && (!capture_on || defer_by_ctl_in);
  wire logic fp_fault_d = lo_fault || hi_fault;

  always_comb
  begin
    psw_d = psw_q;
    if (interruption_in)
      psw_d[`BIT_CAPTURE] = 1'b0;
    else if (restore_in)
      psw_d = restore_data_in;
    else if (do_set)
      psw_d = psw_q | op_bits;
    else if (do_clr)
      psw_d = psw_q & ~op_bits;
    else if (do_move)
      psw_d[31:0] = op_data_in;
  end

  // Armed by an isa switch or return, consumed by the first legacy instruction
  always_comb
  begin
    first_legacy_d = first_legacy_q;
    if (isa_switch_branch_in || restore_in)
      first_legacy_d = 1'b1;
    else if (legacy_mode_in && instr_retire_in)
      first_legacy_d = 1'b0;
  end

  intr_save_reg #(.WIDTH(64)) save_pointer (
    .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .load_in(save_load),
    .data_in(intr_state_in.pointer), .data_out(saved_state_out.pointer));
  intr_save_reg #(.WIDTH(64)) save_status (
    .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .load_in(save_load),
    .data_in(psw_q), .data_out(saved_state_out.status));
  intr_save_reg #(.WIDTH(64)) save_immediate (
    .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .load_in(save_load),
    .data_in(intr_state_in.immediate), .data_out(saved_state_out.immediate));
  intr_save_reg #(.WIDTH(64)) save_frame (
    .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .load_in(save_load),
    .data_in(intr_state_in.frame), .data_out(saved_state_out.frame));

  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      psw_q <= `PSW_RESET;
      first_legacy_q <= 1'b0;
    end
    else
    begin
      psw_q <= psw_d;
      first_legacy_q <= first_legacy_d;
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      ext_take_q <= 1'b0;
      nmi_take_q <= 1'b0;
      defer_q <= 1'b0;
      fp_fault_q <= 1'b0;
    end
    else
    begin
      ext_take_q <= ext_take_d;
      nmi_take_q <= nmi_take_d;
      defer_q <= defer_d;
      fp_fault_q <= fp_fault_d;
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
      mem_ctl_q <= '0;
    else
    begin
      mem_ctl_q.key_instr <= key_on && psw_q[`BIT_ITRANS];
      mem_ctl_q.key_data <= key_on && psw_q[`BIT_DTRANS];
      mem_ctl_q.key_stack <= key_on && psw_q[`BIT_RSTRANS];
      mem_ctl_q.translate_data <= psw_q[`BIT_DTRANS];
      mem_ctl_q.force_defer <= !capture_on;
    end
  end

  assign processor_status_word_out = psw_q;
  assign mem_ctl_out = mem_ctl_q;
  assign ext_intr_take_out = ext_take_q;
  assign nmi_take_out = nmi_take_q;
  assign spec_defer_out = defer_q;
  assign fp_disabled_fault_out = fp_fault_q;

  save_only_capture_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (interruption_in && !capture_on) |=> $stable(saved_state_out))
    else $error("save registers changed with capture off");
  save_when_capture_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (interruption_in && capture_on) |=> (saved_state_out.status == $past(psw_q)) && !psw_q[`BIT_CAPTURE])
    else $error("capture did not save status and clear");
  ext_intr_gate_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (!legacy_mode_in && ext_intr_pending_in && !intr_eff) |=> !ext_intr_take_out)
    else $error("external interrupt taken while disabled");
  clr_next_instr_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (do_clr && !restore_in && op_bits[`BIT_INTR]) |=> !ext_intr_take_out && !psw_q[`BIT_INTR])
    else $error("interrupt bit clear not immediate");
  legacy_ext_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (legacy_mode_in && ext_intr_pending_in && intr_eff && legacy_cfg_intr_flag_in && !legacy_flags_intr_bit_in)
    |=> !ext_intr_take_out)
    else $error("legacy external interrupt not gated by flags");
  legacy_nmi_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (legacy_mode_in && nmi_pending_in && intr_eff) |=> nmi_take_out)
    else $error("legacy nmi not taken");
  defer_no_capture_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (spec_exc_in && !capture_on) |=> spec_defer_out)
    else $error("speculative exception not deferred");
  key_off_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    !key_on |=> !(mem_ctl_out.key_instr || mem_ctl_out.key_data || mem_ctl_out.key_stack))
    else $error("key check with key enable off");
  translate_follow_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    1'b1 |=> mem_ctl_out.translate_data == $past(psw_q[`BIT_DTRANS]))
    else $error("data translation not following control");
  lo_fault_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (psw_q[`BIT_FPLO_DIS] && legacy_fp_instr_in) |=> fp_disabled_fault_out)
    else $error("legacy fp instruction not faulted");
  hi_fault_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (psw_q[`BIT_FPHI_DIS] && fp_access_in && fp_reg_in >= `FP_HI_FIRST) |=> fp_disabled_fault_out)
    else $error("high bank access not faulted");
  mask_range_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (do_set && !restore_in) |=> psw_q[63:24] == $past(psw_q[63:24]))
    else $error("mask op changed bits above 23");
  // Every output is registered, so each check looks one edge after its cause
  save_fields_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (interruption_in && capture_on) |=> (saved_state_out.pointer == $past(intr_state_in.pointer))
    && (saved_state_out.immediate == $past(intr_state_in.immediate))
    && (saved_state_out.frame == $past(intr_state_in.frame)))
    else $error("capture did not save pointer, immediate and frame");
  capture_clear_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    interruption_in |=> !psw_q[`BIT_CAPTURE])
    else $error("interruption left capture set");
  save_idle_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    !interruption_in |=> $stable(saved_state_out))
    else $error("save registers changed without interruption");
  force_defer_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    !capture_on |=> mem_ctl_out.force_defer)
    else $error("deferral not forced with capture off");
  defer_by_ctl_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (spec_exc_in && capture_on) |=> spec_defer_out == $past(defer_by_ctl_in))
    else $error("deferral not following control with capture on");
  native_take_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (!legacy_mode_in && ext_intr_pending_in && intr_eff) |=> ext_intr_take_out)
    else $error("enabled external interrupt not taken");
  no_pending_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    !ext_intr_pending_in |=> !ext_intr_take_out)
    else $error("external interrupt taken with none pending");
  legacy_take_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (legacy_mode_in && ext_intr_pending_in && intr_eff && (!legacy_cfg_intr_flag_in || legacy_flags_intr_bit_in))
    |=> ext_intr_take_out)
    else $error("legacy external interrupt not taken");
  legacy_intr_off_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (legacy_mode_in && !intr_eff) |=> !ext_intr_take_out)
    else $error("legacy external interrupt taken with interrupt bit off");
  legacy_nmi_off_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (legacy_mode_in && !intr_eff) |=> !nmi_take_out)
    else $error("legacy nmi taken with interrupt bit off");
  native_nmi_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (!legacy_mode_in && nmi_pending_in) |=> nmi_take_out)
    else $error("native nmi not taken");
  key_instr_on_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (key_on && psw_q[`BIT_ITRANS]) |=> mem_ctl_out.key_instr)
    else $error("instruction key check missing");
  key_data_on_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (key_on && psw_q[`BIT_DTRANS]) |=> mem_ctl_out.key_data)
    else $error("data key check missing");
  key_stack_on_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (key_on && psw_q[`BIT_RSTRANS]) |=> mem_ctl_out.key_stack)
    else $error("stack key check missing");
  key_instr_off_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    !psw_q[`BIT_ITRANS] |=> !mem_ctl_out.key_instr)
    else $error("instruction key check without translation");
  key_data_off_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    !psw_q[`BIT_DTRANS] |=> !mem_ctl_out.key_data)
    else $error("data key check without translation");
  key_stack_off_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    !psw_q[`BIT_RSTRANS] |=> !mem_ctl_out.key_stack)
    else $error("stack key check without translation");
  phys_data_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    !psw_q[`BIT_DTRANS] |=> !mem_ctl_out.translate_data)
    else $error("data translated with translation off");
  lo_bank_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (psw_q[`BIT_FPLO_DIS] && fp_access_in && fp_reg_in >= `FP_LO_FIRST && fp_reg_in <= `FP_LO_LAST)
    |=> fp_disabled_fault_out)
    else $error("low bank access not faulted");
  first_legacy_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (psw_q[`BIT_FPHI_DIS] && legacy_mode_in && instr_retire_in && first_legacy_q)
    |=> fp_disabled_fault_out)
    else $error("first legacy instruction not faulted");
  arm_legacy_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (isa_switch_branch_in || restore_in) |=> first_legacy_q)
    else $error("first legacy flag not armed");
  fp_enabled_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (!psw_q[`BIT_FPLO_DIS] && !psw_q[`BIT_FPHI_DIS]) |=> !fp_disabled_fault_out)
    else $error("fp fault with both banks enabled");
  clr_range_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (do_clr && !restore_in) |=> psw_q[63:24] == $past(psw_q[63:24]))
    else $error("mask clear changed bits above 23");
  clr_bits_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (do_clr && !restore_in) |=> (psw_q[23:0] & $past(op_bits[23:0])) == 24'h00_0000)
    else $error("mask clear left bits set");
  set_bits_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (do_set && !restore_in) |=> (psw_q[23:0] & $past(op_bits[23:0])) == $past(op_bits[23:0]))
    else $error("mask set left bits clear");
  refused_op_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (!op_privileged_in && !interruption_in && !restore_in) |=> $stable(psw_q))
    else $error("unprivileged op changed status word");
  move_low_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (do_move && !restore_in) |=> psw_q[31:0] == $past(op_data_in))
    else $error("move to low half not applied");
  restore_word_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (restore_in && !interruption_in) |=> psw_q == $past(restore_data_in))
    else $error("return did not restore status word");
  cover_capture_c: cover property (@(posedge ref_clk_in) interruption_in && capture_on);
  cover_clr_intr_c: cover property (@(posedge ref_clk_in) do_clr && op_bits[`BIT_INTR] && ext_intr_pending_in);
  cover_first_legacy_c: cover property (@(posedge ref_clk_in) hi_fault && first_legacy_q);
  cover_legacy_take_c: cover property (@(posedge ref_clk_in) legacy_mode_in && ext_en && ext_intr_pending_in);
  cover_restore_c: cover property (@(posedge ref_clk_in) restore_in && legacy_mode_in);
endmodule : psw_sysmask_ctl

// ---- psw_sysmask_consts.svh ----
`ifndef PSW_SYSMASK_CONSTS_SVH
`define PSW_SYSMASK_CONSTS_SVH
`define PSW_WIDTH 64
`define SYSMASK_HI 23
`define BIT_CAPTURE 13
`define BIT_INTR 14
`define BIT_KEYCHK 15
`define BIT_DTRANS 17
`define BIT_FPLO_DIS 18
`define BIT_FPHI_DIS 19
`define BIT_ITRANS 36
`define BIT_RSTRANS 27
`define PSW_RESET 64'h0000_0000_0000_0000
`define SYSMASK_FIELD 24'hffffff
`define FP_LO_FIRST 7'h02
`define FP_LO_LAST 7'h1f
`define FP_HI_FIRST 7'h20
`endif

// ---- psw_sysmask_pkg.sv ----
package psw_sysmask_pkg;
  typedef enum logic [1:0] {OP_NONE, OP_SET_MASK, OP_CLR_MASK, OP_MOVE_LOW} mask_op_e;
  typedef struct packed {
    logic [63:0] pointer;
    logic [63:0] status;
    logic [63:0] immediate;
    logic [63:0] frame;
  } intr_state_s;
  typedef struct packed {
    logic key_instr;
    logic key_data;
    logic key_stack;
    logic translate_data;
    logic force_defer;
  } mem_ctl_s;
endpackage : psw_sysmask_pkg

// ---- intr_save_reg.sv ----
`timescale 1ns/100ps
// One interruption save register, loaded only when capture is allowed
module intr_save_reg #(
  parameter int WIDTH = 64
) (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic load_in,
  input wire logic [WIDTH-1:0] data_in,
  output logic [WIDTH-1:0] data_out
);
  logic [WIDTH-1:0] data_q;
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
      data_q <= '0;
    else if (load_in)
      data_q <= data_in;
  end
  assign data_out = data_q;
endmodule : intr_save_reg

// ---- test_psw_sysmask_ctl.sv ----
`timescale 1ns/100ps
module test_psw_sysmask_ctl;
  logic ref_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  psw_sysmask_pkg::mask_op_e op_in = psw_sysmask_pkg::OP_NONE;
  logic op_privileged_in = 1'b1;
  logic [31:0] op_data_in = 32'h0;
  logic restore_in = 1'b0;
  logic [63:0] restore_data_in = 64'h0;
  logic interruption_in = 1'b0;
  psw_sysmask_pkg::intr_state_s intr_state_in = '0;
  logic legacy_mode_in = 1'b0, legacy_cfg_intr_flag_in = 1'b0, legacy_flags_intr_bit_in = 1'b0;
  logic ext_intr_pending_in = 1'b0, nmi_pending_in = 1'b0, spec_exc_in = 1'b0, defer_by_ctl_in = 1'b0;
  logic fp_access_in = 1'b0;
  logic [6:0] fp_reg_in = 7'h0;
  logic legacy_fp_instr_in = 1'b0, isa_switch_branch_in = 1'b0, instr_retire_in = 1'b0;
  logic [63:0] processor_status_word_out;
  psw_sysmask_pkg::intr_state_s saved_state_out;
  psw_sysmask_pkg::mem_ctl_s mem_ctl_out;
  logic ext_intr_take_out, nmi_take_out, spec_defer_out, fp_disabled_fault_out;
  int n_fail = 0;
  int num_checks = 0;
  int cycles = 0;
  logic [6:0] regs [5] = '{7'h01, 7'h02, 7'h1f, 7'h20, 7'h7f};
  logic [4:0] lo_exp = 5'b01100;
  logic [4:0] hi_exp = 5'b00011;

  psw_sysmask_ctl u_psw_sysmask_ctl (.ref_clk_in, .sys_rst_in, .op_in, .op_privileged_in, .op_data_in,
    .restore_in, .restore_data_in, .interruption_in, .intr_state_in, .legacy_mode_in,
    .legacy_cfg_intr_flag_in, .legacy_flags_intr_bit_in, .ext_intr_pending_in, .nmi_pending_in,
    .spec_exc_in, .defer_by_ctl_in, .fp_access_in, .fp_reg_in, .legacy_fp_instr_in,
    .isa_switch_branch_in, .instr_retire_in, .processor_status_word_out, .saved_state_out,
    .mem_ctl_out, .ext_intr_take_out, .nmi_take_out, .spec_defer_out, .fp_disabled_fault_out);

  always #4 ref_clk_in = ~ref_clk_in;

  // Whole run needs well under a hundred cycles
  always @(posedge ref_clk_in)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_fail++;
      give_verdict();
    end
  end

  task give_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  task chk(input string what, input logic [255:0] exp, input logic [255:0] got);
    num_checks++;
    if (got !== exp)
    begin
      $display("mismatch %s expected %h seen %h", what, exp, got);
      n_fail++;
    end
  endtask : chk

  // One rising edge, then pulses drop so each lasts exactly one cycle
  task tick();
    @(negedge ref_clk_in);
    op_in = psw_sysmask_pkg::OP_NONE;
    {interruption_in, restore_in, spec_exc_in, fp_access_in} = 4'h0;
    {legacy_fp_instr_in, isa_switch_branch_in, instr_retire_in} = 3'h0;
  endtask : tick

  task op(input psw_sysmask_pkg::mask_op_e o, input logic [31:0] d);
    op_in = o;
    op_data_in = d;
    tick();
  endtask : op

  task t_mask();
    op(psw_sysmask_pkg::OP_SET_MASK, 32'hffff_ffff);
    chk("psw set", 64'h00ff_ffff, processor_status_word_out);
    op(psw_sysmask_pkg::OP_CLR_MASK, 32'hffff_dfff);
    chk("psw clear", 64'h2000, processor_status_word_out);
    op_privileged_in = 1'b0;
    op(psw_sysmask_pkg::OP_SET_MASK, 32'h0000_4000);
    op_privileged_in = 1'b1;
    chk("psw unpriv", 64'h2000, processor_status_word_out);
    $display("test mask done");
  endtask : t_mask

  task t_capture();
    intr_state_in = {64'h1111, 64'h5555, 64'h3333, 64'h4444};
    interruption_in = 1'b1;
    tick();
    chk("saved", {64'h1111, 64'h2000, 64'h3333, 64'h4444}, saved_state_out);
    chk("psw capture off", 64'h0, processor_status_word_out);
    intr_state_in = {64'haaaa, 64'hbbbb, 64'hcccc, 64'hdddd};
    interruption_in = 1'b1;
    tick();
    chk("saved kept", {64'h1111, 64'h2000, 64'h3333, 64'h4444}, saved_state_out);
    spec_exc_in = 1'b1;
    tick();
    chk("defer forced", 1'b1, spec_defer_out);
    op(psw_sysmask_pkg::OP_SET_MASK, 32'h2000);
    spec_exc_in = 1'b1;
    tick();
    chk("defer by ctl", 1'b0, spec_defer_out);
    defer_by_ctl_in = 1'b1;
    spec_exc_in = 1'b1;
    tick();
    defer_by_ctl_in = 1'b0;
    chk("defer by ctl on", 1'b1, spec_defer_out);
    op(psw_sysmask_pkg::OP_CLR_MASK, 32'h2000);
    $display("test capture done");
  endtask : t_capture

  task t_intr();
    ext_intr_pending_in = 1'b1;
    tick();
    chk("take masked", 1'b0, ext_intr_take_out);
    op(psw_sysmask_pkg::OP_SET_MASK, 32'h4000);
    tick();
    chk("take on", 1'b1, ext_intr_take_out);
    op(psw_sysmask_pkg::OP_CLR_MASK, 32'h4000);
    chk("take after clear", 1'b0, ext_intr_take_out);
    op(psw_sysmask_pkg::OP_SET_MASK, 32'h4000);
    op(psw_sysmask_pkg::OP_MOVE_LOW, 32'h0);
    chk("take before serialize", 1'b1, ext_intr_take_out);
    tick();
    chk("take after serialize", 1'b0, ext_intr_take_out);
    op(psw_sysmask_pkg::OP_SET_MASK, 32'h4000);
    legacy_mode_in = 1'b1;
    nmi_pending_in = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      {legacy_cfg_intr_flag_in, legacy_flags_intr_bit_in} = i[1:0];
      tick();
      chk("legacy take", !i[1] || i[0], ext_intr_take_out);
      chk("legacy nmi", 1'b1, nmi_take_out);
    end
    op(psw_sysmask_pkg::OP_CLR_MASK, 32'h4000);
    tick();
    chk("legacy nmi off", 1'b0, nmi_take_out);
    {legacy_mode_in, nmi_pending_in, ext_intr_pending_in} = 3'h0;
    $display("test interrupt done");
  endtask : t_intr

  task keys(input logic [63:0] psw, input logic [4:0] exp);
    restore_in = 1'b1;
    restore_data_in = psw;
    tick();
    tick();
    chk("mem ctl", exp, mem_ctl_out);
  endtask : keys

  task t_keys();
    keys(64'h0000_0010_0802_8000, 5'h1f);
    keys(64'h0000_0010_0802_0000, 5'h03);
    keys(64'h0000_0000_0000_8000, 5'h01);
    keys(64'h0, 5'h01);
    $display("test keys done");
  endtask : t_keys

  task t_fp();
    op(psw_sysmask_pkg::OP_SET_MASK, 32'h4_0000);
    for (int i = 0; i < 10; i++)
    begin
      if (i == 5)
        op(psw_sysmask_pkg::OP_MOVE_LOW, 32'h8_0000);
      fp_access_in = 1'b1;
      fp_reg_in = regs[i % 5];
      tick();
      chk("fp fault", (i < 5) ? lo_exp[4 - i] : hi_exp[9 - i], fp_disabled_fault_out);
      legacy_fp_instr_in = 1'b1;
      tick();
      chk("legacy fp fault", i < 5, fp_disabled_fault_out);
    end
    isa_switch_branch_in = 1'b1;
    tick();
    legacy_mode_in = 1'b1;
    instr_retire_in = 1'b1;
    tick();
    chk("first legacy fault", 1'b1, fp_disabled_fault_out);
    instr_retire_in = 1'b1;
    tick();
    chk("second legacy", 1'b0, fp_disabled_fault_out);
    restore_in = 1'b1;
    restore_data_in = 64'h8_0000;
    tick();
    instr_retire_in = 1'b1;
    tick();
    chk("first after return", 1'b1, fp_disabled_fault_out);
    $display("test fp done");
  endtask : t_fp

  initial
  begin
    repeat (6) @(negedge ref_clk_in);
    sys_rst_in = 1'b0;
    chk("psw reset", 64'h0, processor_status_word_out);
    t_mask();
    t_capture();
    t_intr();
    t_keys();
    t_fp();
    give_verdict();
  end
endmodule : test_psw_sysmask_ctl
